// ### rsm_event_latch.sv
// rsm_event_latch: sticky event flags, cleared by writing ones
// assumes: set and clear are one-cycle pulses on the same clock

`timescale 1ns/1ps

// ============================================================================
// sticky flag bank
module rsm_event_latch #(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] USED  = '1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] setIn,
  input  wire logic [WIDTH-1:0] clearIn,
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } rsm_latch_s;

  rsm_latch_s latchReg;
  rsm_latch_s latchNext;

  if (WIDTH < 1) begin : g_bad_width
    $error("rsm_event_latch: WIDTH must be at least 1");
  end

  // set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    latchNext       = latchReg;
    latchNext.flags = ((latchReg.flags & ~clearIn) | setIn) & USED;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      latchReg <= '0;
    end else begin
      latchReg <= latchNext;
    end
  end

  assign flags = latchReg.flags;

endmodule : rsm_event_latch

// ### rsm_host_model.sv
// rsm_host_model: serial bus host that reaches the register bank
// assumes: the testbench ties the sda wire with a pull-up
`timescale 1ns/1ps

// ======================================================================
// host model
module rsm_host_model #(
  parameter int         HALF = 10,
  parameter logic [6:0] ADDR = rsm_pkg::DEVICE_ADDRESS_DEFAULT
) (
  input  wire logic clock,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      hostPull
);
  // idle bus: scl high and standing still, sda released
  initial begin
    scl = 1'b1;
    hostPull = 1'b0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge clock);
  endtask : wait_half

  // start, or repeated start from mid-frame: sda falls with scl high
  task automatic bus_start();
    @(posedge clock);
    hostPull <= 1'b0;
    wait_half();
    scl <= 1'b1;
    wait_half();
    hostPull <= 1'b1;
    wait_half();
    scl <= 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    @(posedge clock);
    hostPull <= 1'b1;
    wait_half();
    scl <= 1'b1;
    wait_half();
    hostPull <= 1'b0;
    wait_half();
  endtask : bus_stop

  // data moves a clock after scl falls, so it never races the edge
  task automatic bus_bit(input logic txBit, output logic rxBit);
    @(posedge clock);
    hostPull <= !txBit;
    wait_half();
    scl <= 1'b1;
    wait_half();
    rxBit = sdaLine;
    scl <= 1'b0;
  endtask : bus_bit

  // eight bits msb first plus the ninth ack slot
  task automatic bus_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) bus_bit(tx[i], rx[i]);
  endtask : bus_byte

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] data,
                           output logic acked);
    logic [8:0] r0, r1, r2;
    bus_start();
    bus_byte({ADDR, 1'b0, 1'b1}, r0);
    bus_byte({ofs, 1'b1}, r1);
    bus_byte({data, 1'b1}, r2);
    bus_stop();
    acked = !(r0[0] | r1[0] | r2[0]);
  endtask : write_reg

  // a single byte read closed by a host nack
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data,
                          output logic acked);
    logic [8:0] r0, r1, r2, r3;
    bus_start();
    bus_byte({ADDR, 1'b0, 1'b1}, r0);
    bus_byte({ofs, 1'b1}, r1);
    bus_start();
    bus_byte({ADDR, 1'b1, 1'b1}, r2);
    bus_byte(9'h1ff, r3);
    bus_stop();
    data = r3[8:1];
    acked = !(r0[0] | r1[0] | r2[0]);
  endtask : read_reg
endmodule : rsm_host_model

// ### rsm_pkg.sv
// rsm_pkg: shared constants for the regulator status and mask register bank
// assumes: 8-bit register offsets reached over an i2c-compatible target port

// ============================================================================
// register bank constants
package rsm_pkg;

  // ==========================================================================
  // serial target address, plain default
  localparam logic [6:0] DEVICE_ADDRESS_DEFAULT = 7'h60;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_TOP_EVENT       = 8'h19;
  localparam logic [7:0] OFS_SWITCHER_EVENT  = 8'h1b;
  localparam logic [7:0] OFS_LINREG_EVENT    = 8'h1c;
  localparam logic [7:0] OFS_SWITCHER_STATUS = 8'h1e;
  localparam logic [7:0] OFS_LINREG_STATUS   = 8'h1f;
  localparam logic [7:0] OFS_TOP_MASK        = 8'h20;

  // ==========================================================================
  // per-rail field positions, shared by status and event registers
  localparam int RAIL1_ON_BIT      = 7;
  localparam int RAIL1_INVALID_BIT = 6;
  localparam int RAIL1_LIMIT_BIT   = 4;
  localparam int RAIL0_ON_BIT      = 3;
  localparam int RAIL0_INVALID_BIT = 2;
  localparam int RAIL0_LIMIT_BIT   = 0;

  // top mask field positions
  localparam int POWER_OK_SUPPRESS_BIT    = 7;
  localparam int EXT_CLOCK_SUPPRESS_BIT   = 4;
  localparam int HOT_DIE_SUPPRESS_BIT     = 2;
  localparam int LOAD_SAMPLE_SUPPRESS_BIT = 0;

  // ==========================================================================
  // implemented-bit masks and reset values
  localparam logic [7:0] RAIL_STATUS_USED = 8'hdd;
  localparam logic [7:0] RAIL_EVENT_USED  = 8'h55;
  localparam logic [7:0] TOP_MASK_USED    = 8'h95;
  localparam logic [7:0] TOP_MASK_RESET   = 8'h00;
  localparam logic [7:0] FLAG_RESET       = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  // ==========================================================================
  // serial target states
  typedef enum logic [3:0] {
    RSM_IDLE      = 4'h0,
    RSM_ADDR      = 4'h1,
    RSM_ADDR_ACK  = 4'h2,
    RSM_REG       = 4'h3,
    RSM_REG_ACK   = 4'h4,
    RSM_WRITE     = 4'h5,
    RSM_WRITE_ACK = 4'h6,
    RSM_READ      = 4'h7,
    RSM_READ_ACK  = 4'h8
  } rsm_state_e;

endpackage : rsm_pkg

// ### rsm_regbank.sv
// rsm_regbank: raw rail status, sticky rail events and top interrupt mask,
// reached by a host over an i2c-compatible serial target port
// assumes: rail condition inputs are asynchronous levels; top event inputs
// are one-cycle pulses from logic on the same clock; scl/sda are pins
//
// What this block does
// - switcher status bit 7: converter 1 enabled
// - bit 6: converter 1 voltage invalid, raw
// - bit 4: converter 1 current limit, raw
// - switcher status bit 3: converter 0 enabled
// - bit 2: converter 0 voltage invalid, raw
// - bit 0: converter 0 current limit, raw
// - linear status at 0x1f, bit 7: on
// - bit 6: linear 1 voltage invalid, raw
// - bit 4: linear 1 current limit, raw
// - linear status bit 3: linear 0 enabled
// - bit 2: linear 0 voltage invalid, raw
// - bit 0: linear 0 current limit, raw
// - mask bit 7 suppresses power-ok event flag
// - mask bit 4 suppresses external clock event flag
// - mask bit 2 suppresses hot die event flag
// - mask bit 0 suppresses load sample flag
// - event flags stick until host writes one

`timescale 1ns/1ps

// ============================================================================
// top module
module rsm_regbank #(
  parameter logic [6:0] DEVICE_ADDRESS = rsm_pkg::DEVICE_ADDRESS_DEFAULT
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOeN,
  input  wire logic [1:0] switcherOnFlag,
  input  wire logic [1:0] switcherVoltageInvalid,
  input  wire logic [1:0] switcherCurrentLimiting,
  input  wire logic [1:0] linregOnFlag,
  input  wire logic [1:0] linregVoltageInvalid,
  input  wire logic [1:0] linregCurrentLimiting,
  input  wire logic       powerOkEvent,
  input  wire logic       extClockEvent,
  input  wire logic       hotDieEvent,
  input  wire logic       loadSampleEvent
);

  // ==========================================================================
  // state
  typedef struct packed {
    rsm_pkg::rsm_state_e state;
    logic [3:0]          bitCnt;
    logic [7:0]          shiftByte;
    logic [7:0]          regPtr;
    logic                readMode;
    logic                sdaOeN;
    logic                sclPrev;
    logic                sdaPrev;
    logic [7:0]          topMask;
    logic [11:0]         railPrev;
    logic                wrStrobe;
    logic [7:0]          wrOfs;
    logic [7:0]          wrData;
  } rsm_top_s;

  rsm_top_s r_reg;
  rsm_top_s r_next;

  if (DEVICE_ADDRESS == 7'h00) begin : g_bad_addr
    $error("rsm_regbank: address 0 is the general call address");
  end

  // ==========================================================================
  // helpers
  // packs one rail pair into the shared status layout; bits 5 and 1 stay 0
  function automatic logic [7:0] packStatus(
    input logic [1:0] on,
    input logic [1:0] inv,
    input logic [1:0] lim
  );
    logic [7:0] v;
    v = 8'h00;
    v[rsm_pkg::RAIL1_ON_BIT]      = on[1];
    v[rsm_pkg::RAIL1_INVALID_BIT] = inv[1];
    v[rsm_pkg::RAIL1_LIMIT_BIT]   = lim[1];
    v[rsm_pkg::RAIL0_ON_BIT]      = on[0];
    v[rsm_pkg::RAIL0_INVALID_BIT] = inv[0];
    v[rsm_pkg::RAIL0_LIMIT_BIT]   = lim[0];
    packStatus = v & rsm_pkg::RAIL_STATUS_USED;
  endfunction : packStatus

  // event on any change of validity and on entry into current limit
  function automatic logic [7:0] railEvents(
    input logic [1:0] invNow,
    input logic [1:0] invOld,
    input logic [1:0] limNow,
    input logic [1:0] limOld
  );
    logic [7:0] v;
    v = 8'h00;
    v[rsm_pkg::RAIL1_INVALID_BIT] = invNow[1] ^ invOld[1];
    v[rsm_pkg::RAIL1_LIMIT_BIT]   = limNow[1] & ~limOld[1];
    v[rsm_pkg::RAIL0_INVALID_BIT] = invNow[0] ^ invOld[0];
    v[rsm_pkg::RAIL0_LIMIT_BIT]   = limNow[0] & ~limOld[0];
    railEvents = v;
  endfunction : railEvents

  // unmapped offsets read as zero
  function automatic logic [7:0] readReg(
    input logic [7:0] ofs,
    input logic [7:0] swStat,
    input logic [7:0] lrStat,
    input logic [7:0] swEv,
    input logic [7:0] lrEv,
    input logic [7:0] topEv,
    input logic [7:0] mask
  );
    logic [7:0] v;
    v = 8'h00;
    if (ofs == rsm_pkg::OFS_SWITCHER_STATUS) begin
      v = swStat;
    end else if (ofs == rsm_pkg::OFS_LINREG_STATUS) begin
      v = lrStat;
    end else if (ofs == rsm_pkg::OFS_SWITCHER_EVENT) begin
      v = swEv;
    end else if (ofs == rsm_pkg::OFS_LINREG_EVENT) begin
      v = lrEv;
    end else if (ofs == rsm_pkg::OFS_TOP_EVENT) begin
      v = topEv;
    end else if (ofs == rsm_pkg::OFS_TOP_MASK) begin
      v = mask;
    end
    readReg = v;
  endfunction : readReg

  // ==========================================================================
  // synchronisers for pins and rail conditions
  logic [1:0]  busSync;
  logic [11:0] railSync;
  logic        sclS;
  logic        sdaS;

  rsm_sync #(.WIDTH(2), .IDLE_LEVEL(2'h3)) u_bus_sync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn ({scl, sdaIn}),
    .syncOut (busSync)
  );

  rsm_sync #(.WIDTH(12)) u_rail_sync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn ({switcherOnFlag, switcherVoltageInvalid,
               switcherCurrentLimiting, linregOnFlag,
               linregVoltageInvalid, linregCurrentLimiting}),
    .syncOut (railSync)
  );

  assign sclS = busSync[1];
  assign sdaS = busSync[0];

  // ==========================================================================
  // live status, rebuilt every cycle so nothing is held past its cause
  logic [7:0] switcherStatus;
  logic [7:0] linregStatus;

  assign switcherStatus = packStatus(railSync[11:10], railSync[9:8],
                                     railSync[7:6]);
  assign linregStatus   = packStatus(railSync[5:4], railSync[3:2],
                                     railSync[1:0]);

  // ==========================================================================
  // sticky event flags
  logic [7:0] switcherSet;
  logic [7:0] linregSet;
  logic [7:0] topSet;
  logic [7:0] switcherClear;
  logic [7:0] linregClear;
  logic [7:0] topClear;
  logic [7:0] switcherEvents;
  logic [7:0] linregEvents;
  logic [7:0] topEvents;

  assign switcherSet = railEvents(railSync[9:8], r_reg.railPrev[9:8],
                                  railSync[7:6], r_reg.railPrev[7:6]);
  assign linregSet   = railEvents(railSync[3:2], r_reg.railPrev[3:2],
                                  railSync[1:0], r_reg.railPrev[1:0]);

  // the mask gates only the flag; raw status elsewhere is never touched
  always_comb begin
    topSet = 8'h00;
    topSet[rsm_pkg::POWER_OK_SUPPRESS_BIT] = powerOkEvent &
      ~r_reg.topMask[rsm_pkg::POWER_OK_SUPPRESS_BIT];
    topSet[rsm_pkg::EXT_CLOCK_SUPPRESS_BIT] = extClockEvent &
      ~r_reg.topMask[rsm_pkg::EXT_CLOCK_SUPPRESS_BIT];
    topSet[rsm_pkg::HOT_DIE_SUPPRESS_BIT] = hotDieEvent &
      ~r_reg.topMask[rsm_pkg::HOT_DIE_SUPPRESS_BIT];
    topSet[rsm_pkg::LOAD_SAMPLE_SUPPRESS_BIT] = loadSampleEvent &
      ~r_reg.topMask[rsm_pkg::LOAD_SAMPLE_SUPPRESS_BIT];
  end

  // write-one-to-clear strobes from the registered host write
  always_comb begin
    switcherClear = 8'h00;
    linregClear   = 8'h00;
    topClear      = 8'h00;
    if (r_reg.wrStrobe) begin
      if (r_reg.wrOfs == rsm_pkg::OFS_SWITCHER_EVENT) begin
        switcherClear = r_reg.wrData;
      end else if (r_reg.wrOfs == rsm_pkg::OFS_LINREG_EVENT) begin
        linregClear = r_reg.wrData;
      end else if (r_reg.wrOfs == rsm_pkg::OFS_TOP_EVENT) begin
        topClear = r_reg.wrData;
      end
    end
  end

  rsm_event_latch #(.WIDTH(8), .USED(rsm_pkg::RAIL_EVENT_USED)) u_sw_ev (
    .clock   (clock),
    .rst     (rst),
    .setIn   (switcherSet),
    .clearIn (switcherClear),
    .flags   (switcherEvents)
  );

  rsm_event_latch #(.WIDTH(8), .USED(rsm_pkg::RAIL_EVENT_USED)) u_lr_ev (
    .clock   (clock),
    .rst     (rst),
    .setIn   (linregSet),
    .clearIn (linregClear),
    .flags   (linregEvents)
  );

  rsm_event_latch #(.WIDTH(8), .USED(rsm_pkg::TOP_MASK_USED)) u_top_ev (
    .clock   (clock),
    .rst     (rst),
    .setIn   (topSet),
    .clearIn (topClear),
    .flags   (topEvents)
  );

  // ==========================================================================
  // serial target and register writes
  logic       sclRise;
  logic       sclFall;
  logic       busStart;
  logic       busStop;
  logic [7:0] readValue;

  assign sclRise  = sclS & ~r_reg.sclPrev;
  assign sclFall  = ~sclS & r_reg.sclPrev;
  assign busStart = sclS & r_reg.sclPrev & r_reg.sdaPrev & ~sdaS;
  assign busStop  = sclS & r_reg.sclPrev & ~r_reg.sdaPrev & sdaS;
  assign readValue = readReg(r_reg.regPtr, switcherStatus, linregStatus,
                             switcherEvents, linregEvents, topEvents,
                             r_reg.topMask);

  // bits change only on scl low so start and stop stay unambiguous
  always_comb begin
    r_next          = r_reg;
    r_next.sclPrev  = sclS;
    r_next.sdaPrev  = sdaS;
    r_next.railPrev = railSync;
    r_next.wrStrobe = 1'b0;
    // only the mask is stored here; event offsets clear flags elsewhere, status offsets fall through
    if (r_reg.wrStrobe && r_reg.wrOfs == rsm_pkg::OFS_TOP_MASK) begin
      r_next.topMask = r_reg.wrData & rsm_pkg::TOP_MASK_USED;
    end
    if (busStop) begin
      r_next.state  = rsm_pkg::RSM_IDLE;
      r_next.sdaOeN = 1'b1;
    end else if (busStart) begin
      r_next.state  = rsm_pkg::RSM_ADDR;
      r_next.bitCnt = 4'h0;
      r_next.sdaOeN = 1'b1;
    end else begin
      case (r_reg.state)
        rsm_pkg::RSM_ADDR, rsm_pkg::RSM_REG, rsm_pkg::RSM_WRITE: begin
          if (sclRise) begin
            r_next.shiftByte = {r_reg.shiftByte[6:0], sdaS};
            r_next.bitCnt    = r_reg.bitCnt + 4'h1;
          end else if (sclFall && r_reg.bitCnt == rsm_pkg::BITS_PER_BYTE) begin
            r_next.bitCnt = 4'h0;
            r_next.sdaOeN = 1'b0;
            if (r_reg.state == rsm_pkg::RSM_ADDR) begin
              if (r_reg.shiftByte[7:1] == DEVICE_ADDRESS) begin
                r_next.readMode = r_reg.shiftByte[0];
                r_next.state    = rsm_pkg::RSM_ADDR_ACK;
              end else begin
                r_next.sdaOeN = 1'b1;
                r_next.state  = rsm_pkg::RSM_IDLE;
              end
            end else if (r_reg.state == rsm_pkg::RSM_REG) begin
              r_next.regPtr = r_reg.shiftByte;
              r_next.state  = rsm_pkg::RSM_REG_ACK;
            end else begin
              r_next.wrStrobe = 1'b1;
              r_next.wrOfs    = r_reg.regPtr;
              r_next.wrData   = r_reg.shiftByte;
              r_next.regPtr   = r_reg.regPtr + 8'h01;
              r_next.state    = rsm_pkg::RSM_WRITE_ACK;
            end
          end
        end
        rsm_pkg::RSM_ADDR_ACK: begin
          if (sclFall && r_reg.readMode) begin
            r_next.shiftByte = readValue;
            r_next.sdaOeN    = readValue[7];
            r_next.regPtr    = r_reg.regPtr + 8'h01;
            r_next.state     = rsm_pkg::RSM_READ;
          end else if (sclFall) begin
            r_next.sdaOeN = 1'b1;
            r_next.state  = rsm_pkg::RSM_REG;
          end
        end
        rsm_pkg::RSM_REG_ACK, rsm_pkg::RSM_WRITE_ACK: begin
          if (sclFall) begin
            r_next.sdaOeN = 1'b1;
            r_next.state  = rsm_pkg::RSM_WRITE;
          end
        end
        rsm_pkg::RSM_READ: begin
          if (sclRise) begin
            r_next.bitCnt = r_reg.bitCnt + 4'h1;
          end else if (sclFall && r_reg.bitCnt == rsm_pkg::BITS_PER_BYTE) begin
            r_next.bitCnt = 4'h0;
            r_next.sdaOeN = 1'b1;
            r_next.state  = rsm_pkg::RSM_READ_ACK;
          end else if (sclFall) begin
            r_next.shiftByte = {r_reg.shiftByte[6:0], 1'b0};
            r_next.sdaOeN    = r_reg.shiftByte[6];
          end
        end
        rsm_pkg::RSM_READ_ACK: begin
          // a nack from the host ends the read burst
          if (sclRise && sdaS) begin
            r_next.state = rsm_pkg::RSM_IDLE;
          end else if (sclFall) begin
            r_next.shiftByte = readValue;
            r_next.sdaOeN    = readValue[7];
            r_next.regPtr    = r_reg.regPtr + 8'h01;
            r_next.state     = rsm_pkg::RSM_READ;
          end
        end
        default: begin
          r_next.sdaOeN = 1'b1;
        end
      endcase
    end
  end

  // mask resets to a fixed value; there is no stored default to load
  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg         <= '0;
      r_reg.state   <= rsm_pkg::RSM_IDLE;
      r_reg.sdaOeN  <= 1'b1;
      r_reg.sclPrev <= 1'b1;
      r_reg.sdaPrev <= 1'b1;
      r_reg.topMask <= rsm_pkg::TOP_MASK_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sdaOut = 1'b0; // open drain: only ever pulls low
  assign sdaOeN = r_reg.sdaOeN;

endmodule : rsm_regbank

// ### rsm_regbank_sva.sv
// rsm_regbank_sva: pin-level checks on the serial target of rsm_regbank
// assumes: the host keeps every scl half period at ten clocks or more
`timescale 1ns/1ps

// ======================================================================
// checker
module rsm_regbank_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOeN
);
  typedef struct packed {
    logic sdaPrev;
    logic frameOpen;
  } rsm_chk_s;
  rsm_chk_s state_reg;
  rsm_chk_s state_next;

  // frame tracker on raw pins; the target sees them two flops later
  always_comb begin
    state_next = state_reg;
    state_next.sdaPrev = sdaIn;
    if (scl && state_reg.sdaPrev && !sdaIn) state_next.frameOpen = 1'b1;
    if (scl && !state_reg.sdaPrev && sdaIn) state_next.frameOpen = 1'b0;
  end

  // tracker register
  always_ff @(posedge clock) begin
    if (rst) state_reg <= 2'b10;
    else state_reg <= state_next;
  end

  // ======================================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence sclHighRun;
    scl [*4];
  endsequence

  sequence heldLow;
    !sdaOeN [*8];
  endsequence

  a_reset_release: assert property (disable iff (1'b0) rst |=> sdaOeN)
    else $error("sda enable not released after reset");
  a_idle_after_reset: assert property ($fell(rst) |-> sdaOeN [*8])
    else $error("sda pulled right after reset");
  a_drive_scl_low: assert property ($fell(sdaOeN) |-> !scl && !$past(scl))
    else $error("sda pulled while scl high");
  a_release_scl_low: assert property ($rose(sdaOeN) |-> !scl)
    else $error("sda released while scl high");
  a_quiet_scl_high: assert property (sclHighRun |-> $stable(sdaOeN))
    else $error("sda enable moved during scl high");
  a_hold_bit_low: assert property ($fell(sdaOeN) |-> heldLow)
    else $error("driven bit shorter than eight clocks");
  a_drive_in_frame: assert property ($fell(sdaOeN) |-> state_reg.frameOpen)
    else $error("sda pulled outside a frame");
  a_open_drain_zero: assert property (sdaOut == 1'b0)
    else $error("sda data value not zero");
endmodule : rsm_regbank_sva

bind rsm_regbank rsm_regbank_sva chk (
  .clock  (clock),
  .rst    (rst),
  .scl    (scl),
  .sdaIn  (sdaIn),
  .sdaOut (sdaOut),
  .sdaOeN (sdaOeN)
);

// ### rsm_regbank_tb_top.sv
// rsm_regbank_tb_top: self-checking bench for the regulator register bank
// assumes: rsm_host_model drives the bus; the checker is bound in
`timescale 1ns/1ps

// ======================================================================
// bench
module rsm_regbank_tb_top;
  localparam logic [7:0] SW = rsm_pkg::OFS_SWITCHER_STATUS;
  localparam logic [7:0] LR = rsm_pkg::OFS_LINREG_STATUS;
  localparam logic [7:0] SE = rsm_pkg::OFS_SWITCHER_EVENT;
  localparam logic [7:0] LE = rsm_pkg::OFS_LINREG_EVENT;
  localparam logic [7:0] TE = rsm_pkg::OFS_TOP_EVENT;
  localparam logic [7:0] TM = rsm_pkg::OFS_TOP_MASK;
  logic        clock;
  logic        rst;
  logic        scl;
  logic        hostPull;
  logic        sdaOut;
  logic        sdaOeN;
  logic [11:0] rail;
  logic [3:0]  ev;
  int          badCount;
  int          comparisons;
  wire logic   sdaLine;

  // open-drain wire with pull-up: low if either side pulls
  assign sdaLine = !(hostPull || !sdaOeN);

  // 200 MHz clock
  initial clock = 1'b0;
  always #2.5 clock = !clock;

  rsm_host_model #(.HALF(10)) host (
    .clock    (clock),
    .sdaLine  (sdaLine),
    .scl      (scl),
    .hostPull (hostPull)
  );

  rsm_regbank uut (
    .clock                   (clock),
    .rst                     (rst),
    .scl                     (scl),
    .sdaIn                   (sdaLine),
    .sdaOut                  (sdaOut),
    .sdaOeN                  (sdaOeN),
    .switcherOnFlag          (rail[11:10]),
    .switcherVoltageInvalid  (rail[9:8]),
    .switcherCurrentLimiting (rail[7:6]),
    .linregOnFlag            (rail[5:4]),
    .linregVoltageInvalid    (rail[3:2]),
    .linregCurrentLimiting   (rail[1:0]),
    .powerOkEvent            (ev[3]),
    .extClockEvent           (ev[2]),
    .hotDieEvent             (ev[1]),
    .loadSampleEvent         (ev[0])
  );

  // r = {on1, on0, invalid1, invalid0, limit1, limit0}
  function automatic logic [7:0] status_of(input logic [5:0] r);
    return {r[5], r[3], 1'b0, r[1], r[4], r[2], 1'b0, r[0]};
  endfunction : status_of

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
    logic ok;
    host.write_reg(ofs, data, ok);
    check("write ack", {7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rd_check(input string what, input logic [7:0] ofs,
                          input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.read_reg(ofs, d, ok);
    check("read ack", {7'h00, ok}, 8'h01);
    check(what, d, exp);
  endtask : rd_check

  task automatic pulse_events();
    @(posedge clock);
    ev <= 4'hf;
    @(posedge clock);
    ev <= 4'h0;
  endtask : pulse_events

  task automatic test_reset_values();
    rd_check("mask reset", TM, 8'h00);
    rd_check("top events reset", TE, 8'h00);
    $display("test reset values done");
  endtask : test_reset_values

  // one rail input high at a time, then all low again
  task automatic test_status_walk();
    logic [7:0] swExp, lrExp;
    for (int i = 0; i < 13; i++) begin
      @(posedge clock);
      rail <= (i < 12) ? (12'h001 << i) : 12'h000;
      repeat (4) @(posedge clock);
      swExp = status_of(rail[11:6]);
      lrExp = status_of(rail[5:0]);
      rd_check("switcher", SW, swExp);
      rd_check("linreg", LR, lrExp);
    end
    $display("test status walk done");
  endtask : test_status_walk

  // the walk changed every invalid bit and raised every limit bit
  task automatic test_rail_events();
    rd_check("switcher events", SE, 8'h55);
    rd_check("linreg events", LE, 8'h55);
    wr(SE, 8'h55);
    wr(LE, 8'h55);
    rd_check("switcher cleared", SE, 8'h00);
    rd_check("linreg cleared", LE, 8'h00);
    $display("test rail events done");
  endtask : test_rail_events

  task automatic test_read_only();
    @(posedge clock);
    rail <= 12'hb6d;
    repeat (4) @(posedge clock);
    wr(SW, 8'hff);
    wr(LR, 8'h00);
    rd_check("switcher kept", SW, status_of(6'h2d));
    rd_check("linreg kept", LR, status_of(6'h2d));
    rd_check("unmapped", 8'h30, 8'h00);
    $display("test read only done");
  endtask : test_read_only

  // each suppress bit alone, after all of them together
  task automatic test_mask();
    logic [7:0] sel [4];
    sel = '{8'h80, 8'h10, 8'h04, 8'h01};
    wr(TM, 8'hff);
    rd_check("mask used bits", TM, 8'h95);
    pulse_events();
    rd_check("all suppressed", TE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(TM, sel[k]);
      pulse_events();
      rd_check("one suppressed", TE, 8'h95 & ~sel[k]);
      wr(TE, 8'hff);
      rd_check("top cleared", TE, 8'h00);
    end
    $display("test mask done");
  endtask : test_mask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // hang guard: the full run needs well under this many cycles
  initial begin
    repeat (95000) @(posedge clock);
    $display("watchdog expired");
    badCount++;
    print_verdict();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    rail = 12'h000;
    ev = 4'h0;
    badCount = 0;
    comparisons = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    test_reset_values();
    test_status_walk();
    test_rail_events();
    test_read_only();
    test_mask();
    print_verdict();
  end
endmodule : rsm_regbank_tb_top

// ### rsm_sync.sv
// rsm_sync: two flip-flop synchroniser for a vector of levels
// assumes: each bit is an independent slow level from outside the clock

`timescale 1ns/1ps

// ============================================================================
// synchroniser
module rsm_sync #(
  parameter int               WIDTH      = 1,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } rsm_sync_s;

  rsm_sync_s syncReg;
  rsm_sync_s syncNext;

  if (WIDTH < 1) begin : g_bad_width
    $error("rsm_sync: WIDTH must be at least 1");
  end

  // stage1 feeds only stage2, never any logic
  always_comb begin
    syncNext        = syncReg;
    syncNext.stage1 = asyncIn;
    syncNext.stage2 = syncReg.stage1;
  end

  // reset to the idle level so no false edge follows reset
  always_ff @(posedge clock) begin
    if (rst) begin
      syncReg <= {IDLE_LEVEL, IDLE_LEVEL};
    end else begin
      syncReg <= syncNext;
    end
  end

  assign syncOut = syncReg.stage2;

endmodule : rsm_sync
